// File: core/drive_identity_pkg.sv
/*
 * Package for the drive identity and error reporting objects: object
 * indices, subindices, field positions, preset values and abort codes.
 * Assumes an object dictionary engine that presents index/subindex requests.
 */
// Operation
// - Read-only 32-bit kind word: motor type high half, profile number low half.
// - Bits 23..16 of kind word: 1 means servo drive, 2 means stepper.
// - Low half of kind word holds the fixed supported profile code.
// - Read-only 8-bit error summary, preset zero, mappable into transmitted data.
// - Summary bits follow their conditions and clear themselves without acknowledgement.
// - Summary bits: general, current, voltage, temperature, comms, profile, zero, vendor.
// - Vendor-specific bit 7 sets when motor turns in the wrong direction.
// - History of eight read-only 32-bit entries, preset zero, plus writable count.
// - New error goes to entry one; older entries shift back, oldest dropped.
// - Writing zero to the count restarts history counting from the beginning.
// - Entry reads with empty history are refused with the no-data abort code.
package drive_identity_pkg;
	localparam logic [15:0] IDX_KIND_WORD = 16'h1000;
	localparam logic [15:0] IDX_SUMMARY = 16'h1001;
	localparam logic [15:0] IDX_HISTORY = 16'h1003;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam int MOTOR_TYPE_LSB = 16;
	localparam int PROFILE_LSB = 0;
	localparam logic [7:0] DRIVE_SERVO = 8'h01;
	localparam logic [7:0] DRIVE_STEPPER = 8'h02;
	localparam logic [7:0] SUMMARY_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [31:0] ENTRY_RESET = 32'h00000000;
	localparam int HISTORY_DEPTH = 8;
	localparam int BIT_GENERAL = 0;
	localparam int BIT_CURRENT = 1;
	localparam int BIT_VOLTAGE = 2;
	localparam int BIT_TEMP = 3;
	localparam int BIT_COMMS = 4;
	localparam int BIT_PROFILE = 5;
	localparam int BIT_RESERVED = 6;
	localparam int BIT_VENDOR = 7;
	localparam logic [31:0] ABORT_NO_DATA = 32'h08000024;
	localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
	localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
	localparam logic [31:0] ABORT_NO_SUB = 32'h06090011;
	localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;
endpackage : drive_identity_pkg

// File: core/drive_identity_error_objects.sv
/*
 * Identity and error reporting objects of the drive: kind word, error
 * summary and the error history stack with its count.
 * Assumes requests come one at a time from the dictionary engine on clk,
 * and error conditions and error events are synchronous to clk.
 */
module drive_identity_error_objects
	import drive_identity_pkg::*;
#(
	parameter logic [15:0] PROFILE_CODE = 16'h0001, // arbitrary value
	parameter logic [7:0] DRIVE_KIND = DRIVE_STEPPER,
	parameter int DEPTH = HISTORY_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [15:0] req_index,
	input wire logic [7:0] req_subindex,
	input wire logic [31:0] req_wdata,
	output logic rsp_valid,
	output logic rsp_abort,
	output logic [31:0] rsp_data,
	input wire logic general_fault_flag,
	input wire logic current_fault_flag,
	input wire logic voltage_fault_flag,
	input wire logic temperature_fault_flag,
	input wire logic communication_fault_flag,
	input wire logic profile_fault_flag,
	input wire logic wrong_direction,
	input wire logic error_event,
	input wire logic [31:0] error_word,
	output logic [7:0] error_summary
);
	initial begin
		if (DEPTH != HISTORY_DEPTH) $error("history depth must be eight");
		if (DRIVE_KIND != DRIVE_SERVO && DRIVE_KIND != DRIVE_STEPPER)
			$error("drive kind must be servo or stepper");
	end

	typedef struct packed {
		logic [HISTORY_DEPTH-1:0][31:0] entry;
		logic [7:0] count;
		logic [7:0] summary;
		logic rsp_valid;
		logic rsp_abort;
		logic [31:0] rsp_data;
	} state_type;

	state_type cur;
	state_type nxt;

	logic [31:0] device_kind_word;
	logic [7:0] live_summary;
	logic reserved_flag;
	logic count_zero_write;
	logic [7:0] count_base;

	// Count that a same-cycle event starts from; the zero write is taken first
	assign count_zero_write = req_valid && req_write && req_index == IDX_HISTORY
		&& req_subindex == SUB_COUNT && req_wdata == 32'h00000000;
	assign count_base = count_zero_write ? COUNT_RESET : cur.count;

	// Upper byte of motor type half unused, so it stays zero
	assign device_kind_word = ({24'h000000, DRIVE_KIND} << MOTOR_TYPE_LSB)
		| ({16'h0000, PROFILE_CODE} << PROFILE_LSB);
	assign reserved_flag = 1'b0;

	always_comb begin
		live_summary = SUMMARY_RESET;
		live_summary[BIT_GENERAL] = general_fault_flag;
		live_summary[BIT_CURRENT] = current_fault_flag;
		live_summary[BIT_VOLTAGE] = voltage_fault_flag;
		live_summary[BIT_TEMP] = temperature_fault_flag;
		live_summary[BIT_COMMS] = communication_fault_flag;
		live_summary[BIT_PROFILE] = profile_fault_flag;
		live_summary[BIT_RESERVED] = reserved_flag;
		live_summary[BIT_VENDOR] = wrong_direction;
	end

	always_comb begin
		nxt = cur;
		nxt.rsp_valid = 1'b0;
		nxt.rsp_abort = 1'b0;
		// Summary tracks live conditions, no latching so no acknowledge needed
		nxt.summary = live_summary;
		if (req_valid) begin
			nxt.rsp_valid = 1'b1;
			nxt.rsp_data = 32'h00000000;
			unique case (req_index)
				IDX_KIND_WORD: begin
					if (req_subindex != SUB_COUNT)
						nxt.rsp_abort = 1'b1;
					else if (req_write)
						nxt.rsp_abort = 1'b1;
					else
						nxt.rsp_data = device_kind_word;
				end
				IDX_SUMMARY: begin
					if (req_subindex != SUB_COUNT || req_write)
						nxt.rsp_abort = 1'b1;
					else
						nxt.rsp_data = {24'h000000, cur.summary};
				end
				IDX_HISTORY: begin
					if (req_subindex == SUB_COUNT) begin
						if (!req_write)
							nxt.rsp_data = {24'h000000, cur.count};
						else if (req_wdata == 32'h00000000)
							nxt.count = COUNT_RESET;
						else
							nxt.rsp_abort = 1'b1;
					end else if (req_subindex > 8'(HISTORY_DEPTH)) begin
						nxt.rsp_abort = 1'b1;
					end else if (req_write) begin
						nxt.rsp_abort = 1'b1;
					end else if (cur.count == COUNT_RESET) begin
						nxt.rsp_abort = 1'b1;
					end else begin
						nxt.rsp_data = cur.entry[3'(req_subindex - 8'h01)];
					end
				end
				default: nxt.rsp_abort = 1'b1;
			endcase
			if (nxt.rsp_abort)
				nxt.rsp_data = abort_code(req_index, req_subindex, req_write, cur.count);
		end
		// A same-cycle event counts on from a zero write of the count, leaving one
		if (error_event) begin
			for (int i = HISTORY_DEPTH - 1; i > 0; i--)
				nxt.entry[i] = cur.entry[i-1];
			nxt.entry[0] = error_word;
			if (nxt.count < 8'(HISTORY_DEPTH))
				nxt.count = nxt.count + 8'h01;
		end
	end

	function automatic logic [31:0] abort_code(input logic [15:0] idx,
		input logic [7:0] sub, input logic wr, input logic [7:0] cnt);
		logic [31:0] code;
		code = ABORT_NO_OBJECT;
		if (idx == IDX_KIND_WORD || idx == IDX_SUMMARY)
			code = (sub != SUB_COUNT) ? ABORT_NO_SUB : ABORT_READ_ONLY;
		else if (idx == IDX_HISTORY) begin
			if (sub == SUB_COUNT)
				code = ABORT_BAD_VALUE;
			else if (sub > 8'(HISTORY_DEPTH))
				code = ABORT_NO_SUB;
			else if (wr)
				code = ABORT_READ_ONLY;
			else if (cnt == COUNT_RESET)
				code = ABORT_NO_DATA;
		end
		return code;
	endfunction : abort_code

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.entry <= {HISTORY_DEPTH{ENTRY_RESET}};
			cur.count <= COUNT_RESET;
			cur.summary <= SUMMARY_RESET;
			cur.rsp_valid <= 1'b0;
			cur.rsp_abort <= 1'b0;
			cur.rsp_data <= 32'h00000000;
		end else begin
			cur <= nxt;
		end
	end

	assign rsp_valid = cur.rsp_valid;
	assign rsp_abort = cur.rsp_abort;
	assign rsp_data = cur.rsp_data;
	assign error_summary = cur.summary;

	property p_kind_read;
		@(posedge clk) disable iff (!rst_n)
		req_valid && !req_write && req_index == IDX_KIND_WORD && req_subindex == SUB_COUNT
		|=> rsp_valid && !rsp_abort && rsp_data[23:16] == DRIVE_KIND
			&& rsp_data[15:0] == PROFILE_CODE && rsp_data[31:24] == 8'h00;
	endproperty
	a_kind_read: assert property (p_kind_read) else $error("kind word wrong");

	property p_kind_ro;
		@(posedge clk) disable iff (!rst_n)
		req_valid && req_write && req_index == IDX_KIND_WORD |=> rsp_abort;
	endproperty
	a_kind_ro: assert property (p_kind_ro) else $error("kind word write taken");

	property p_summary_follows;
		@(posedge clk) disable iff (!rst_n)
		##1 error_summary == {$past(wrong_direction), 1'b0, $past(profile_fault_flag),
			$past(communication_fault_flag), $past(temperature_fault_flag),
			$past(voltage_fault_flag), $past(current_fault_flag), $past(general_fault_flag)};
	endproperty
	a_summary_follows: assert property (p_summary_follows) else $error("summary mismatch");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n) error_summary[BIT_RESERVED] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_vendor_bit;
		@(posedge clk) disable iff (!rst_n)
		wrong_direction |=> error_summary[BIT_VENDOR];
	endproperty
	a_vendor_bit: assert property (p_vendor_bit) else $error("vendor bit missing");

	property p_push;
		@(posedge clk) disable iff (!rst_n)
		error_event |=> cur.entry[0] == $past(error_word) && cur.entry[1] == $past(cur.entry[0]);
	endproperty
	a_push: assert property (p_push) else $error("history shift wrong");

	property p_count;
		@(posedge clk) disable iff (!rst_n)
		error_event |=> cur.count == (($past(count_base) >= 8'h08) ? 8'h08
			: $past(count_base) + 8'h01);
	endproperty
	a_count: assert property (p_count) else $error("count wrong");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		req_valid && req_write && req_index == IDX_HISTORY && req_subindex == SUB_COUNT
		&& req_wdata == 32'h0 && !error_event |=> cur.count == 8'h00 && !rsp_abort;
	endproperty
	a_clear: assert property (p_clear) else $error("count not cleared");

	property p_empty_abort;
		@(posedge clk) disable iff (!rst_n)
		req_valid && !req_write && req_index == IDX_HISTORY && req_subindex != SUB_COUNT
		&& req_subindex <= 8'h08 && cur.count == 8'h00
		|=> rsp_abort && rsp_data == ABORT_NO_DATA;
	endproperty
	a_empty_abort: assert property (p_empty_abort) else $error("empty read not refused");

	property p_one_cycle;
		@(posedge clk) disable iff (!rst_n) rsp_valid |-> ##1 (rsp_valid == $past(req_valid));
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("answer timing wrong");

	property p_answer_taken;
		@(posedge clk) disable iff (!rst_n)
		req_valid |=> rsp_valid;
	endproperty
	a_answer_taken: assert property (p_answer_taken) else $error("answer missing");

	property p_no_stray;
		@(posedge clk) disable iff (!rst_n)
		!req_valid |=> !rsp_valid;
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without request");

	property p_summary_read;
		@(posedge clk) disable iff (!rst_n)
		req_valid && !req_write && req_index == IDX_SUMMARY && req_subindex == SUB_COUNT
		|=> !rsp_abort && rsp_data == {24'h000000, $past(error_summary)};
	endproperty
	a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

	property p_newest_read;
		@(posedge clk) disable iff (!rst_n)
		req_valid && !req_write && req_index == IDX_HISTORY && req_subindex == 8'h01
		&& cur.count != 8'h00 |=> !rsp_abort && rsp_data == $past(cur.entry[0]);
	endproperty
	a_newest_read: assert property (p_newest_read) else $error("newest entry wrong");

	property p_entry_ro;
		@(posedge clk) disable iff (!rst_n)
		req_valid && req_write && req_index == IDX_HISTORY && req_subindex != SUB_COUNT
		&& req_subindex <= 8'h08 |=> rsp_abort && rsp_data == ABORT_READ_ONLY;
	endproperty
	a_entry_ro: assert property (p_entry_ro) else $error("entry write taken");

	property p_count_limit;
		@(posedge clk) disable iff (!rst_n)
		cur.count <= 8'h08;
	endproperty
	a_count_limit: assert property (p_count_limit) else $error("count above eight");

	property p_count_hold;
		@(posedge clk) disable iff (!rst_n)
		!error_event && !count_zero_write |=> cur.count == $past(cur.count);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved");

	property p_entries_hold;
		@(posedge clk) disable iff (!rst_n)
		!error_event |=> cur.entry == $past(cur.entry);
	endproperty
	a_entries_hold: assert property (p_entries_hold) else $error("history moved");

	property p_bad_count_write;
		@(posedge clk) disable iff (!rst_n)
		req_valid && req_write && req_index == IDX_HISTORY && req_subindex == SUB_COUNT
		&& req_wdata != 32'h00000000 |=> rsp_abort && rsp_data == ABORT_BAD_VALUE;
	endproperty
	a_bad_count_write: assert property (p_bad_count_write) else $error("bad count taken");

	c_event: cover property (@(posedge clk) disable iff (!rst_n) error_event);
	c_full: cover property (@(posedge clk) disable iff (!rst_n) cur.count == 8'h08);
	c_empty_read: cover property (@(posedge clk) disable iff (!rst_n)
		rsp_abort && rsp_data == ABORT_NO_DATA);
	c_entry_read: cover property (@(posedge clk) disable iff (!rst_n)
		rsp_valid && !rsp_abort && $past(req_index) == IDX_HISTORY);
endmodule : drive_identity_error_objects

// File: tb/fieldbus_master.sv
/*
 * Fieldbus master model: issues one dictionary request per call of xfer.
 * Assumes the caller enters xfer just after a rising clk edge.
 */
module fieldbus_master (
	input wire logic clk,
	output logic req_valid,
	output logic req_write,
	output logic [15:0] req_index,
	output logic [7:0] req_subindex,
	output logic [31:0] req_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_index = 16'h0000;
		req_subindex = 8'h00;
		req_wdata = 32'h00000000;
	end
	task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d);
		req_valid <= 1'b1;
		req_write <= w;
		req_index <= i;
		req_subindex <= s;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		// Released qualifiers never keep the last value
		req_write <= ~w;
		req_index <= ~i;
		req_subindex <= ~s;
		req_wdata <= ~d;
	endtask : xfer
endmodule : fieldbus_master

// File: tb/drive_identity_error_objects_test.sv
/*
 * Self-checking bench for the identity and error objects.
 * Assumes answers arrive one cycle after each taken request.
 */
module drive_identity_error_objects_test import drive_identity_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] PCODE = 16'h0A5C; // arbitrary value
	logic clk, rst_n, req_valid, req_write, rsp_valid, rsp_abort, error_event;
	logic [15:0] req_index;
	logic [7:0] req_subindex, error_summary, exp_sum;
	logic [31:0] req_wdata, rsp_data, error_word;
	logic [6:0] cond;
	logic [33:0] note;
	logic [33:0] exp_q[$];
	logic [31:0] hist[8];
	int mismatches, checks_done, seed;
	fieldbus_master u_fieldbus_master (.clk(clk), .req_valid(req_valid),
		.req_write(req_write), .req_index(req_index), .req_subindex(req_subindex),
		.req_wdata(req_wdata));
	drive_identity_error_objects #(.PROFILE_CODE(PCODE), .DRIVE_KIND(DRIVE_SERVO))
		u_drive_identity_error_objects (.clk(clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_write(req_write), .req_index(req_index),
		.req_subindex(req_subindex), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_abort(rsp_abort), .rsp_data(rsp_data), .general_fault_flag(cond[0]),
		.current_fault_flag(cond[1]), .voltage_fault_flag(cond[2]),
		.temperature_fault_flag(cond[3]), .communication_fault_flag(cond[4]),
		.profile_fault_flag(cond[5]), .wrong_direction(cond[6]),
		.error_event(error_event), .error_word(error_word),
		.error_summary(error_summary));
	task automatic check(input logic [31:0] e, input logic [31:0] g, input string m);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t %s exp %h got %h", $time, m, e, g);
		end
	endtask : check
	// Note is {compare data, abort, data}
	task automatic op(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [33:0] n);
		exp_q.push_back(n);
		@(posedge clk);
		u_fieldbus_master.xfer(w, i, s, 32'h00000000);
	endtask : op
	task automatic err(input logic [31:0] w);
		@(posedge clk);
		error_event <= 1'b1;
		error_word <= w;
		@(posedge clk);
		error_event <= 1'b0;
		error_word <= ~w;
		for (int k = 7; k > 0; k--) hist[k] = hist[k - 1];
		hist[0] = w;
	endtask : err
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	always @(posedge clk) if (rsp_valid === 1'b1) begin
		if (exp_q.size() == 0) check(32'h00000001, 32'h00000000, "stray answer");
		else begin
			note = exp_q.pop_front();
			check({31'h00000000, note[32]}, {31'h00000000, rsp_abort}, "abort flag");
			if (note[33]) check(note[31:0], rsp_data, "answer data");
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	initial begin
		seed = 32'hDE39CC99;
		rst_n = 1'b0;
		cond = 7'h00;
		error_event = 1'b0;
		error_word = 32'h00000000;
		hist = '{default: 32'h00000000};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		op(1'b0, IDX_KIND_WORD, 8'h00, {2'b10, 8'h00, DRIVE_SERVO, PCODE});
		op(1'b0, IDX_SUMMARY, 8'h00, {2'b10, 32'h00000000});
		op(1'b0, IDX_HISTORY, SUB_COUNT, {2'b10, 32'h00000000});
		op(1'b0, IDX_HISTORY, 8'h01, {2'b11, ABORT_NO_DATA});
		op(1'b1, IDX_KIND_WORD, 8'h00, {2'b11, ABORT_READ_ONLY});
		op(1'b1, IDX_SUMMARY, 8'h00, {2'b11, ABORT_READ_ONLY});
		op(1'b1, IDX_HISTORY, 8'h01, {2'b11, ABORT_READ_ONLY});
		repeat (11) err($random(seed));
		op(1'b0, IDX_HISTORY, SUB_COUNT, {2'b10, 32'h00000008});
		for (int k = 0; k < 8; k++)
			op(1'b0, IDX_HISTORY, 8'(k + 1), {2'b10, hist[k]});
		op(1'b1, IDX_HISTORY, SUB_COUNT, {2'b00, 32'h00000000});
		op(1'b0, IDX_HISTORY, SUB_COUNT, {2'b10, 32'h00000000});
		op(1'b0, IDX_HISTORY, 8'h01, {2'b11, ABORT_NO_DATA});
		err($random(seed));
		op(1'b0, IDX_HISTORY, SUB_COUNT, {2'b10, 32'h00000001});
		op(1'b0, IDX_HISTORY, 8'h01, {2'b10, hist[0]});
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			cond <= (k == 11) ? 7'h00 : 7'($random(seed));
			repeat (2) @(posedge clk);
			exp_sum = {cond[6], 1'b0, cond[5:0]};
			check({24'h000000, exp_sum}, {24'h000000, error_summary}, "summary");
			op(1'b0, IDX_SUMMARY, 8'h00, {2'b10, 24'h000000, exp_sum});
		end
		repeat (3) @(posedge clk);
		check(32'h00000000, 32'(exp_q.size()), "answers missing");
		end_of_test();
	end
endmodule : drive_identity_error_objects_test
